// file: rtl/sspp_pkg.sv
package sspp_pkg;

  // Serial word geometry
  localparam int unsigned WORD_W    = 24;
  localparam int unsigned CTRL_W    = 2;
  localparam int unsigned PAYLOAD_W = WORD_W - CTRL_W;

  // Destination select carried in the two low bits
  typedef enum logic [1:0] {
    SSPP_DST_REF  = 2'h0,
    SSPP_DST_FB   = 2'h1,
    SSPP_DST_FUNC = 2'h2,
    SSPP_DST_INIT = 2'h3
  } sspp_dst_t;

  // One shifted word, control bits at the bottom
  typedef struct packed {
    logic [PAYLOAD_W-1:0] payload;
    sspp_dst_t            dst;
  } sspp_word_t;

  // Monitor select field inside the function word
  localparam int unsigned MON_SEL_LSB = 4;
  localparam int unsigned MON_SEL_W   = 3;

  // Monitor select codes
  localparam logic [2:0] MON_LOW       = 3'h0;
  localparam logic [2:0] MON_LOCK      = 3'h1;
  localparam logic [2:0] MON_ACTIVE    = 3'h2;
  localparam logic [2:0] MON_POWERDOWN = 3'h3;
  localparam logic [2:0] MON_HIGH      = 3'h7;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

  // Tracks the feedback load that follows an initialization
  typedef enum logic [1:0] {
    SSPP_IDLE  = 2'h0,
    SSPP_ARMED = 2'h1
  } sspp_init_st_t;

  // Status outputs grouped together
  typedef struct packed {
    logic output_active;
    logic powered_down;
    logic counter_reset;
  } sspp_status_t;

endpackage

// file: rtl/sspp_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Shift data in on each serial clock rise
// - Strobe rising edge copies word to latch
// - Status output active after ref, fb, init writes, while chip enable is high
// - Monitor pin selectable, includes lock indicator
// - Low two bits pick destination latch
// - Init write loads function, pulses counter reset
// - Serial port keeps working while powered down
module sspp_port (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        serial_clk,
  input  wire logic                        serial_data,
  input  wire logic                        latch_strobe,
  input  wire logic                        chip_enable,
  input  wire logic                        lock_indicator,
  output logic [sspp_pkg::WORD_W-1:0]      ref_latch,
  output logic [sspp_pkg::WORD_W-1:0]      fb_latch,
  output logic [sspp_pkg::WORD_W-1:0]      func_latch,
  output sspp_pkg::sspp_status_t           status,
  output logic                             monitor_output_pin
);

  // ---------------- Serial clock domain ----------------

  // Input shift register, data only so it needs no reset
  logic [sspp_pkg::WORD_W-1:0] shift_q;
  logic [sspp_pkg::WORD_W-1:0] shift_d;

  // Next shift value; oldest bit falls off the top
  always_comb begin
    shift_d = {shift_q[sspp_pkg::WORD_W-2:0], serial_data};
  end

  // Shifting never looks at power state
  // No reset here: the serial clock may be stopped during sys_rst,
  // and every complete frame overwrites all 24 bits anyway.
  // Leading junk bits simply fall off the top of the register.
  always_ff @(posedge serial_clk) begin
    shift_q <= shift_d;
  end

  // ---------------- System clock domain ----------------

  // Pin synchronisers; stage one feeds only stage two
  logic [2:0] stb_q;     // Strobe: two sync stages plus edge history
  logic [2:0] stb_d;
  logic [1:0] ce_q;      // Chip enable sync
  logic [1:0] ce_d;
  logic [1:0] lock_q;    // Lock indicator sync
  logic [1:0] lock_d;

  // Next values of the synchronisers
  always_comb begin
    stb_d  = {stb_q[1:0], latch_strobe};
    ce_d   = {ce_q[0], chip_enable};
    lock_d = {lock_q[0], lock_indicator};
  end

  // Register synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stb_q  <= 3'h0;
      ce_q   <= 2'h0;
      lock_q <= 2'h0;
    end else begin
      stb_q  <= stb_d;
      ce_q   <= ce_d;
      lock_q <= lock_d;
    end
  end

  // Strobe rise, seen on stages two and three only
  // The history stage clears with the rest, so a strobe that is
  // already high when reset lets go is taken for an edge.
  // A strobe that is high for less than a clock may be missed.
  logic strobe_rise;
  assign strobe_rise = stb_q[1] & ~stb_q[2];

  // Captured word. The host holds the serial clock still while the
  // strobe is high, so the shift register is quiet by the time the
  // synchronised edge arrives; the strobe itself is the handshake.
  sspp_pkg::sspp_word_t word;
  assign word = sspp_pkg::sspp_word_t'(shift_q);

  // Latch bank and power-up tracking
  logic [sspp_pkg::WORD_W-1:0] ref_q;
  logic [sspp_pkg::WORD_W-1:0] ref_d;
  logic [sspp_pkg::WORD_W-1:0] fb_q;
  logic [sspp_pkg::WORD_W-1:0] fb_d;
  logic [sspp_pkg::WORD_W-1:0] func_q;
  logic [sspp_pkg::WORD_W-1:0] func_d;
  logic                        seen_ref_q;   // Reference written once
  logic                        seen_ref_d;
  logic                        seen_fb_q;    // Feedback written once
  logic                        seen_fb_d;
  logic                        seen_init_q;  // Init written once
  logic                        seen_init_d;
  logic                        cnt_rst_q;    // Counter reset pulse
  logic                        cnt_rst_d;
  sspp_pkg::sspp_init_st_t     init_st_q;    // Post-init tracking
  sspp_pkg::sspp_init_st_t     init_st_d;

  // Only the first feedback load after an init repeats the pulse;
  // later feedback loads leave the counters running.
  // Decode destination and compute latch updates
  always_comb begin
    ref_d       = ref_q;
    fb_d        = fb_q;
    func_d      = func_q;
    seen_ref_d  = seen_ref_q;
    seen_fb_d   = seen_fb_q;
    seen_init_d = seen_init_q;
    cnt_rst_d   = 1'b0;
    init_st_d   = init_st_q;
    // Loads go ahead regardless of chip enable
    if (strobe_rise) begin
      case (word.dst)
        sspp_pkg::SSPP_DST_REF: begin
          ref_d      = shift_q;
          seen_ref_d = 1'b1;
        end
        sspp_pkg::SSPP_DST_FB: begin
          fb_d      = shift_q;
          seen_fb_d = 1'b1;
          // First feedback load after init repeats the reset
          if (init_st_q == sspp_pkg::SSPP_ARMED) begin
            cnt_rst_d = 1'b1;
            init_st_d = sspp_pkg::SSPP_IDLE;
          end
        end
        sspp_pkg::SSPP_DST_FUNC: begin
          func_d = shift_q;
        end
        default: begin
          // Init loads function settings and resets counters
          func_d      = shift_q;
          cnt_rst_d   = 1'b1;
          seen_init_d = 1'b1;
          init_st_d   = sspp_pkg::SSPP_ARMED;
        end
      endcase
    end
  end

  // Register the latch bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_q       <= sspp_pkg::WORD_RST;
      fb_q        <= sspp_pkg::WORD_RST;
      func_q      <= sspp_pkg::WORD_RST;
      seen_ref_q  <= 1'b0;
      seen_fb_q   <= 1'b0;
      seen_init_q <= 1'b0;
      cnt_rst_q   <= 1'b0;
      init_st_q   <= sspp_pkg::SSPP_IDLE;
    end else begin
      ref_q       <= ref_d;
      fb_q        <= fb_d;
      func_q      <= func_d;
      seen_ref_q  <= seen_ref_d;
      seen_fb_q   <= seen_fb_d;
      seen_init_q <= seen_init_d;
      cnt_rst_q   <= cnt_rst_d;
      init_st_q   <= init_st_d;
    end
  end

  // Output stays inactive until all three kinds were written
  logic active;
  assign active = seen_ref_q & seen_fb_q & seen_init_q;

  // Monitor selection from the function word
  logic [sspp_pkg::MON_SEL_W-1:0] mon_sel;
  assign mon_sel =
    func_q[sspp_pkg::MON_SEL_LSB +: sspp_pkg::MON_SEL_W];

  // Monitor pin and status, registered
  logic         mon_q;
  logic         mon_d;

  // Power-down and lock codes read synchronised pins, so the monitor
  // lags those pins by three clock edges.
  // Pick the monitored signal; unknown codes read low
  always_comb begin
    if (mon_sel == sspp_pkg::MON_LOCK) begin
      mon_d = lock_q[1];
    end else if (mon_sel == sspp_pkg::MON_ACTIVE) begin
      mon_d = active;
    end else if (mon_sel == sspp_pkg::MON_POWERDOWN) begin
      mon_d = ~ce_q[1];
    end else if (mon_sel == sspp_pkg::MON_HIGH) begin
      mon_d = 1'b1;
    end else begin
      mon_d = 1'b0;
    end
  end

  // Register the monitor pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_q <= 1'b0;
    end else begin
      mon_q <= mon_d;
    end
  end

  // Status active also needs the enable; a disabled device reports idle here
  // but not on the monitor's active code, and its latches keep their programming.
  // Drive outputs from flops
  assign ref_latch            = ref_q;
  assign fb_latch             = fb_q;
  assign func_latch           = func_q;
  assign status.output_active = active & ce_q[1];
  assign status.powered_down  = ~ce_q[1];
  assign status.counter_reset = cnt_rst_q;
  assign monitor_output_pin   = mon_q;

endmodule

// file: sim/sspp_port_chk.sv
`timescale 1ns/100ps
module sspp_port_chk (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         latch_strobe,
  input wire logic                         chip_enable,
  input wire logic [sspp_pkg::WORD_W-1:0]  ref_latch,
  input wire logic [sspp_pkg::WORD_W-1:0]  fb_latch,
  input wire logic [sspp_pkg::WORD_W-1:0]  func_latch,
  input wire sspp_pkg::sspp_status_t       status,
  input wire logic                         monitor_output_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Latches only move on their own code
  a_ref_dest: assert property ($changed(ref_latch) |-> ref_latch[1:0] == 2'h0)
    else $error("ref latch took a foreign word");
  a_fb_dest: assert property ($changed(fb_latch) |-> fb_latch[1:0] == 2'h1)
    else $error("fb latch took a foreign word");
  a_func_dest: assert property ($changed(func_latch) |-> func_latch[1])
    else $error("func latch took a foreign word");
  // Strobe still high two cycles before commit
  a_ref_cause: assert property ($changed(ref_latch) |-> $past(latch_strobe, 2))
    else $error("ref latch moved without strobe");
  a_pulse_once: assert property (status.counter_reset |=> !status.counter_reset)
    else $error("counter reset wider than a cycle");
  a_pulse_cause: assert property (status.counter_reset |-> $past(latch_strobe, 2))
    else $error("counter reset without strobe");
  // Sync depth is two, five leaves margin
  a_pd_follow: assert property (!chip_enable [*5] |-> status.powered_down)
    else $error("power-down not shown");
  a_active_off: assert property (!chip_enable [*5] |-> !status.output_active)
    else $error("active while powered down");
  a_mon_high: assert property (func_latch[6:4] == 3'h7 && $stable(func_latch) |-> monitor_output_pin)
    else $error("monitor not high");
  c_init: cover property (status.counter_reset);
  c_pd_write: cover property (status.powered_down && $changed(ref_latch));
  c_lock: cover property (func_latch[6:4] == 3'h1 && monitor_output_pin);
endmodule
bind sspp_port sspp_port_chk u_chk (.clk, .sys_rst, .latch_strobe,
  .chip_enable, .ref_latch, .fb_latch, .func_latch, .status,
  .monitor_output_pin);

// file: sim/sspp_host.sv
`timescale 1ns/100ps
module sspp_host (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  // Clock idles low and stands still between frames
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Three bytes MSB first, junk bits lead when extra > 0
  task automatic send(input logic [23:0] w, input int extra);
    latch_strobe = 1'b0;
    // Random lead-in keeps the link unrelated in phase to clk
    #(400 + $urandom_range(29));
    for (int i = 23 + extra; i >= 0; i--) begin
      serial_data = i > 23 ? 1'($urandom) : w[i];
      #15 serial_clk = 1'b1;
      #15 serial_clk = 1'b0;
    end
    // Released line must not look like a held bit
    serial_data = ~serial_data;
    #15 latch_strobe = 1'b1;
    #600;
  endtask
endmodule

// file: sim/synth_serial_program_port_tb.sv
`timescale 1ns/100ps
module synth_serial_program_port_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_enable = 1'b1;
  logic lock_indicator = 1'b0;
  logic sclk, sdat, stb, mon;
  logic [23:0] ref_latch, fb_latch, func_latch;
  logic [71:0] prev;
  sspp_pkg::sspp_status_t status;
  logic [25:0] exp_q[$];
  logic [25:0] got;
  logic [21:0] p;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pulses = 0;
  int exp_pulses = 0;
  logic armed = 1'b0;
  always #50 clk = ~clk;
  sspp_host host (.serial_clk(sclk), .serial_data(sdat), .latch_strobe(stb));
  sspp_port dut (.clk, .sys_rst, .serial_clk(sclk), .serial_data(sdat),
    .latch_strobe(stb), .chip_enable, .lock_indicator, .ref_latch,
    .fb_latch, .func_latch, .status, .monitor_output_pin(mon));
  task automatic chk(input logic [25:0] g, input logic [25:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Note the result, then frame the word
  task automatic wr(input logic [1:0] d, input logic [21:0] q);
    exp_q.push_back({d == 2'h3 ? 2'h2 : d, q, d});
    // Init pulses the counters, and so does the next feedback load
    if (d == 2'h3) begin
      exp_pulses++;
      armed = 1'b1;
    end else if (d == 2'h1 && armed) begin
      exp_pulses++;
      armed = 1'b0;
    end
    host.send({q, d}, $urandom_range(8));
    repeat (6) @(negedge clk);
  endtask
  // Oldest note against whichever latch moved
  always @(negedge clk) begin
    if (!sys_rst && {ref_latch, fb_latch, func_latch} !== prev) begin
      got = ref_latch !== prev[71:48] ? {2'h0, ref_latch}
          : fb_latch !== prev[47:24] ? {2'h1, fb_latch} : {2'h2, func_latch};
      chk(got, exp_q.size() ? exp_q.pop_front() : 26'h0);
    end
    prev = {ref_latch, fb_latch, func_latch};
    if (!sys_rst && status.counter_reset)
      pulses++;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h7b0b));
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    for (int d = 0; d < 3; d++)
      wr(2'(d), 22'($urandom));
    chk(26'(status.output_active), 26'h0);
    p = 22'($urandom);
    p[4:2] = sspp_pkg::MON_LOCK;
    wr(2'h3, p);
    chk(26'(status.output_active), 26'h1);
    lock_indicator = 1'b1;
    repeat (5) @(negedge clk);
    chk(26'(mon), 26'h1);
    // Every select code, lock and active held high
    for (int c = 0; c < 8; c++) begin
      p = 22'($urandom);
      p[4:2] = 3'(c);
      wr(2'h2, p);
      chk(26'(mon), 26'((8'h86 >> c) & 8'h1));
    end
    chip_enable = 1'b0;
    p[4:2] = sspp_pkg::MON_POWERDOWN;
    wr(2'h2, p);
    chk(26'({mon, status[2:1]}), 26'h5);
    chip_enable = 1'b1;
    repeat (6) wr(2'($urandom), 22'($urandom));
    chk(26'(exp_q.size()), 26'h0);
    chk(26'(pulses), 26'(exp_pulses));
    end_of_test();
  end
endmodule
